/* rtl/fsl_ctrl.v */
// fsl_ctrl.v: host-side lock-bit set sequencer for a parallel flash
// assumes: AHB-Lite single word transfers; flash pins are asynchronous
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`include "fsl_defs.vh"
module fsl_ctrl (
    input  wire                   CLK,
    input  wire                   RST_B,
    input  wire [31:0]            HADDR,
    input  wire [1:0]             HTRANS,
    input  wire                   HWRITE,
    input  wire [2:0]             HSIZE,
    input  wire [31:0]            HWDATA,
    input  wire                   HSEL,
    input  wire                   HREADY,
    output reg  [31:0]            HRDATA,
    output reg                    HREADYOUT,
    output reg                    HRESP,
    output wire [`FSL_ADDR_W-1:0] FLASH_A,
    input  wire [7:0]             FLASH_DQ_I,
    output wire [7:0]             FLASH_DQ_O,
    output wire                   FLASH_DQ_OE,
    output wire                   FLASH_CE_N,
    output wire                   FLASH_OE_N,
    output wire                   FLASH_WE_N,
    input  wire                   READY_BUSY_N_PIN,
    output reg                    RESET_POWERDOWN_N_PIN
);
    // ============================================================
    // reset release
    // two flops so the release never lands close to an edge
    reg rst_s1_reg;
    reg rst_n;
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end
    // ============================================================
    // pin synchronisers
    // data bus and ready pin are not of this clock
    reg [7:0] dq_s1_reg;
    reg [7:0] dq_sync;
    reg       rb_s1_reg;
    reg       rb_sync;
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_reg <= 8'h00;
            dq_sync   <= 8'h00;
            rb_s1_reg <= 1'b0;
            rb_sync   <= 1'b0;
        end else begin
            dq_s1_reg <= FLASH_DQ_I;
            dq_sync   <= dq_s1_reg;
            rb_s1_reg <= READY_BUSY_N_PIN;
            rb_sync   <= rb_s1_reg;
        end
    end
    // ============================================================
    // sequencer states
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_SETUP = 4'h1;
    localparam [3:0] ST_CONF  = 4'h2;
    localparam [3:0] ST_POLL  = 4'h3;
    localparam [3:0] ST_CHECK = 4'h4;
    localparam [3:0] ST_CLR   = 4'h5;
    localparam [3:0] ST_FIN   = 4'h6;
    localparam [3:0] ST_RDCMD = 4'h7;
    reg [3:0]             state_reg;
    reg [`FSL_ADDR_W-1:0] addr_reg;
    reg                   master_reg;
    reg                   full_reg;
    reg [7:0]             status_reg;
    reg [4:0]             fault_reg;
    reg                   done_reg;
    reg                   bc_req;
    reg                   bc_wr;
    reg [7:0]             bc_wdata;
    wire                  bc_done;
    wire [7:0]            bc_rdata;
    wire                  busy = (state_reg != ST_IDLE);
    fsl_bus_cycle u_cycle (
        .clk       (CLK),
        .rst_n     (rst_n),
        .req       (bc_req),
        .wr        (bc_wr),
        .addr      (addr_reg),
        .wdata     (bc_wdata),
        .dq_sync   (dq_sync),
        .done      (bc_done),
        .rdata     (bc_rdata),
        .a_reg     (FLASH_A),
        .dq_o_reg  (FLASH_DQ_O),
        .dq_oe_reg (FLASH_DQ_OE),
        .ce_n_reg  (FLASH_CE_N),
        .oe_n_reg  (FLASH_OE_N),
        .we_n_reg  (FLASH_WE_N)
    );
    // ============================================================
    // classify a ready status byte into fault bits
    // fault: {protect, vpp, sequence, set error, erase error}
    function [4:0] classify;
        input [7:0] sr;
        reg   [7:0] m;
        begin
            m = sr & `FSL_SR_MASK;
            classify = {m[`FSL_SR_PROT],
                        m[`FSL_SR_VPP],
                        m[`FSL_SR_EERR] & m[`FSL_SR_PERR],
                        m[`FSL_SR_PERR],
                        m[`FSL_SR_EERR]};
        end
    endfunction
    // ============================================================
    // AHB-Lite slave: address phase capture
    reg        dp_valid_reg;
    reg        dp_write_reg;
    reg [7:0]  dp_addr_reg;
    // one offset decoder shared by the write strobes and the read mux
    function reg_at;
        input [7:0] a;
        input [7:0] off;
        begin
            reg_at = (a == off);
        end
    endfunction
    wire       ap_take = HSEL && HREADY && HTRANS[1];
    wire       wr_ctrl = dp_valid_reg && dp_write_reg && reg_at(dp_addr_reg, `FSL_OFF_CTRL);
    wire       wr_addr = dp_valid_reg && dp_write_reg && reg_at(dp_addr_reg, `FSL_OFF_ADDR);
    wire       go      = wr_ctrl && HWDATA[`FSL_CTRL_GO] && !busy;
    wire       clr     = wr_ctrl && HWDATA[`FSL_CTRL_CLEAR] && !busy;
    wire       fin     = wr_ctrl && HWDATA[`FSL_CTRL_FINISH] && !busy;
    // ============================================================
    // register read mux
    // status word: pin, done, busy, polling, last byte
    wire        polling   = (state_reg == ST_POLL);
    wire [31:0] stat_word = {20'h0, rb_sync, done_reg, busy, polling, status_reg};
    reg [31:0] rd_next;
    always @* begin
        if (reg_at(dp_addr_reg, `FSL_OFF_CTRL)) begin
            rd_next = {29'h0, full_reg, master_reg, 1'b0};
        end else if (reg_at(dp_addr_reg, `FSL_OFF_ADDR)) begin
            rd_next = {11'h0, addr_reg};
        end else if (reg_at(dp_addr_reg, `FSL_OFF_STAT)) begin
            rd_next = stat_word;
        end else if (reg_at(dp_addr_reg, `FSL_OFF_FSTAT)) begin
            rd_next = {27'h0, fault_reg};
        end else begin
            rd_next = 32'h0;
        end
    end
    // ============================================================
    // data phase: writes take no wait state, reads one
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg  <= 8'h00;
            HRDATA       <= 32'h0;
            HREADYOUT    <= 1'b1;
            HRESP        <= 1'b0;
        end else begin
            if (HREADY) begin
                dp_valid_reg <= ap_take;
                dp_write_reg <= HWRITE;
                dp_addr_reg  <= {HADDR[7:2], 2'b00};
            end
            // only OKAY: no register refuses a word
            HRESP <= 1'b0;
            // read data registered: reads take one wait state
            if (ap_take && !HWRITE) begin
                HREADYOUT <= 1'b0;
            end else if (!HREADYOUT) begin
                HRDATA    <= rd_next;
                HREADYOUT <= 1'b1;
            end
        end
    end
    // ============================================================
    // lock-set sequencer
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg             <= ST_IDLE;
            addr_reg              <= {`FSL_ADDR_W{1'b0}};
            master_reg            <= 1'b0;
            full_reg              <= 1'b0;
            status_reg            <= 8'h80;
            fault_reg             <= 5'h00;
            done_reg              <= 1'b0;
            bc_req                <= 1'b0;
            bc_wr                 <= 1'b0;
            bc_wdata              <= 8'h00;
            RESET_POWERDOWN_N_PIN <= 1'b0;
        end else begin
            RESET_POWERDOWN_N_PIN <= 1'b1;
            if (wr_addr && !busy) begin
                addr_reg <= HWDATA[`FSL_ADDR_W-1:0];
            end
            if (wr_ctrl && !busy) begin
                master_reg <= HWDATA[`FSL_CTRL_MASTER];
                full_reg   <= HWDATA[`FSL_CTRL_FULL];
            end
            case (state_reg)
                ST_IDLE: begin
                    // go wins over clear, clear over finish
                    if (go) begin
                        done_reg  <= 1'b0;
                        bc_req    <= 1'b1;
                        bc_wr     <= 1'b1;
                        bc_wdata  <= `FSL_CMD_SETUP;
                        state_reg <= ST_SETUP;
                    end else if (clr) begin
                        bc_req    <= 1'b1;
                        bc_wr     <= 1'b1;
                        bc_wdata  <= `FSL_CMD_CLRSTAT;
                        fault_reg <= 5'h00;
                        state_reg <= ST_CLR;
                    end else if (fin) begin
                        bc_req    <= 1'b1;
                        bc_wr     <= 1'b1;
                        bc_wdata  <= `FSL_CMD_READ;
                        state_reg <= ST_FIN;
                    end
                end
                ST_SETUP: begin
                    if (bc_done) begin
                        bc_wdata  <= master_reg ? `FSL_CMD_MASTER : `FSL_CMD_BLOCK;
                        state_reg <= ST_CONF;
                    end
                end
                ST_CONF: begin
                    if (bc_done) begin
                        bc_wr     <= 1'b0;
                        state_reg <= ST_POLL;
                    end
                end
                ST_POLL: begin
                    // device answers status reads after the confirm write
                    if (bc_done) begin
                        if (bc_rdata[`FSL_SR_READY]) begin
                            status_reg <= bc_rdata;
                        end else begin
                            // low bits are junk while busy; keep the busy mark only
                            status_reg <= {1'b0, status_reg[6:0]};
                        end
                        if (bc_rdata[`FSL_SR_READY] && rb_sync) begin
                            bc_req    <= 1'b0;
                            state_reg <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    // or in, never overwrite: bits stay until a clear
                    if (full_reg) begin
                        fault_reg <= fault_reg | classify(status_reg);
                    end
                    done_reg  <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_CLR: begin
                    if (bc_done) begin
                        bc_req    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FIN: begin
                    if (bc_done) begin
                        bc_req    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    bc_req    <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fsl_ctrl

/* rtl/fsl_defs.vh */
// fsl_defs.vh: constants for the flash lock-set controller
// assumes: included by the design files of the controller only
`ifndef FSL_DEFS_VH
`define FSL_DEFS_VH
// ============================================================
// controller register offsets (byte addresses, one word each)
`define FSL_OFF_CTRL      8'h00
`define FSL_OFF_ADDR      8'h04
`define FSL_OFF_STAT      8'h08
`define FSL_OFF_FSTAT     8'h0C
// ============================================================
// control register fields
`define FSL_CTRL_GO       0
`define FSL_CTRL_MASTER   1
`define FSL_CTRL_FULL     2
`define FSL_CTRL_CLEAR    3
`define FSL_CTRL_FINISH   4
// ============================================================
// flash commands
`define FSL_CMD_SETUP     8'h60
`define FSL_CMD_BLOCK     8'h01
`define FSL_CMD_MASTER    8'hF1
`define FSL_CMD_READ      8'hFF
`define FSL_CMD_RDSTAT    8'h70
`define FSL_CMD_CLRSTAT   8'h50
// ============================================================
// status register bit positions
`define FSL_SR_READY      7
`define FSL_SR_ESUSP      6
`define FSL_SR_EERR       5
`define FSL_SR_PERR       4
`define FSL_SR_VPP        3
`define FSL_SR_PSUSP      2
`define FSL_SR_PROT       1
`define FSL_SR_MASK       8'hFE
// ============================================================
// flash bus timing: 120 ns at 40 ns per cycle, rounded up
`define FSL_T_ACC_NS      120
`define FSL_CLK_NS        40
`define FSL_T_ACC_CYC     ((`FSL_T_ACC_NS + `FSL_CLK_NS - 1) / `FSL_CLK_NS)
`define FSL_ADDR_W        21
`endif

/* rtl/fsl_bus_cycle.v */
// fsl_bus_cycle.v: one flash write or read cycle on the async pins
// assumes: caller holds req until done; pins are idle between cycles
`include "fsl_defs.vh"
module fsl_bus_cycle (
    input  wire                  clk,
    input  wire                  rst_n,
    input  wire                  req,
    input  wire                  wr,
    input  wire [`FSL_ADDR_W-1:0] addr,
    input  wire [7:0]            wdata,
    input  wire [7:0]            dq_sync,
    output reg                   done,
    output reg  [7:0]            rdata,
    output reg  [`FSL_ADDR_W-1:0] a_reg,
    output reg  [7:0]            dq_o_reg,
    output reg                   dq_oe_reg,
    output reg                   ce_n_reg,
    output reg                   oe_n_reg,
    output reg                   we_n_reg
);
    // ============================================================
    // strobe timing
    // two sync stages delay read data, so the strobe holds longer
    localparam integer STROBE_CYC = `FSL_T_ACC_CYC + 2;
    localparam [3:0]   STROBE     = STROBE_CYC[3:0];
    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_STB  = 2'b01;
    localparam [1:0] S_REC  = 2'b10;
    reg [1:0] state_reg;
    reg [3:0] cnt_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            cnt_reg   <= 4'h0;
            done      <= 1'b0;
            rdata     <= 8'h00;
            a_reg     <= {`FSL_ADDR_W{1'b0}};
            dq_o_reg  <= 8'h00;
            dq_oe_reg <= 1'b0;
            ce_n_reg  <= 1'b1;
            oe_n_reg  <= 1'b1;
            we_n_reg  <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (req && !done) begin
                        a_reg     <= addr;
                        dq_o_reg  <= wdata;
                        dq_oe_reg <= wr;
                        ce_n_reg  <= 1'b0;
                        we_n_reg  <= ~wr;
                        oe_n_reg  <= wr;
                        cnt_reg   <= STROBE;
                        state_reg <= S_STB;
                    end
                end
                S_STB: begin
                    if (cnt_reg == 4'h0) begin
                        rdata     <= dq_sync;
                        we_n_reg  <= 1'b1;
                        oe_n_reg  <= 1'b1;
                        ce_n_reg  <= 1'b1;
                        state_reg <= S_REC;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: begin
                    // data held one cycle past the write strobe edge
                    dq_oe_reg <= 1'b0;
                    done      <= 1'b1;
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fsl_bus_cycle

/* verification/fsl_ctrl_assertions.sv */
// fsl_ctrl_assertions.sv: port checks of the lock-set controller
// assumes: bound to fsl_ctrl, flash strobes are registered levels
module fsl_ctrl_checker (
    input logic        CLK,
    input logic        RST_B,
    input logic [1:0]  HTRANS,
    input logic        HWRITE,
    input logic        HSEL,
    input logic        HREADY,
    input logic        HREADYOUT,
    input logic [20:0] FLASH_A,
    input logic [7:0]  FLASH_DQ_O,
    input logic        FLASH_DQ_OE,
    input logic        FLASH_CE_N,
    input logic        FLASH_OE_N,
    input logic        FLASH_WE_N,
    input logic        RESET_POWERDOWN_N_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // last byte written, so a confirm pairs with its setup
    logic       we_q;
    logic [7:0] last_cmd;
    wire        take = HSEL && HREADY && HTRANS[1];
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            we_q     <= 1'h1;
            last_cmd <= 8'h00;
        end else begin
            we_q <= FLASH_WE_N;
            if (FLASH_WE_N && !we_q)
                last_cmd <= FLASH_DQ_O;
        end
    end
    // ============================================================
    // properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_we_width: assert property ($fell(FLASH_WE_N) |-> !FLASH_WE_N [*6] ##1 FLASH_WE_N)
        else $error("write strobe not six cycles");
    a_we_qual: assert property (!FLASH_WE_N |-> !FLASH_CE_N && FLASH_DQ_OE && FLASH_OE_N)
        else $error("write strobe without select or data");
    a_dq_release: assert property ($rose(FLASH_WE_N) |-> FLASH_DQ_OE ##1 !FLASH_DQ_OE)
        else $error("data not released after recovery");
    a_read_clash: assert property (!FLASH_OE_N |-> !FLASH_DQ_OE && FLASH_WE_N)
        else $error("read strobe while driving data");
    a_addr_hold: assert property (!FLASH_WE_N && !$past(FLASH_WE_N) |->
        $stable(FLASH_A) && $stable(FLASH_DQ_O)) else $error("address or data moved in strobe");
    a_confirm_pair: assert property ($fell(FLASH_WE_N) |->
        (last_cmd == 8'h60) == (FLASH_DQ_O inside {8'h01, 8'hF1}))
        else $error("confirm and setup out of pair");
    a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read not one wait state");
    a_write_zero: assert property (take && HWRITE |=> HREADYOUT)
        else $error("write not zero wait");
    a_rp_release: assert property ($rose(RST_B) |->
        !RESET_POWERDOWN_N_PIN ##[1:4] RESET_POWERDOWN_N_PIN) else $error("power-down pin late");
endmodule // fsl_ctrl_checker

bind fsl_ctrl fsl_ctrl_checker i_chk (
    .CLK, .RST_B, .HTRANS, .HWRITE, .HSEL, .HREADY, .HREADYOUT, .FLASH_A, .FLASH_DQ_O,
    .FLASH_DQ_OE, .FLASH_CE_N, .FLASH_OE_N, .FLASH_WE_N, .RESET_POWERDOWN_N_PIN);

/* verification/fsl_flash_model.sv */
// fsl_flash_model.sv: behavioural flash device for the bench
// assumes: clk times the busy period and samples the strobes from the controller
module fsl_flash_model (
    input  logic        clk,
    input  logic [20:0] a,
    input  logic [7:0]  d_in,
    input  logic        ce_n,
    input  logic        oe_n,
    input  logic        we_n,
    input  logic        rp_n,
    input  logic        vpp_low,
    input  logic        rp_vhh,
    input  logic [7:0]  busy_cyc,
    output logic [7:0]  dq,
    output logic        rb_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  sr = 8'h80, cmd = 8'h00, last = 8'h00;
    logic [6:0]  noise = 7'h00;
    logic [20:0] conf_a = 21'h0;
    logic        setup = 1'h0, arr = 1'h1, mlock = 1'h0, wq = 1'h1;
    int          cnt = 0;
    wire         rd_on = !ce_n && !oe_n;
    // ============================================================
    // junk below bit 7 while busy; bit 0 high to prove masking
    assign dq = !rd_on ? ~last : cnt != 0 ? {1'h0, noise} : arr ? 8'h00 : sr | 8'h01;
    assign rb_n = !rp_n || cnt == 0;
    always @(posedge clk) begin
        wq <= ce_n | we_n;
        noise <= 7'($urandom);
        if (rd_on)
            last <= dq;
        if (!rp_n) begin
            sr <= 8'h80;
            setup <= 1'h0;
            arr <= 1'h1;
            cnt <= 0;
        end else if (cnt > 1)
            cnt <= cnt - 1;
        else if (cnt == 1) begin
            cnt <= 0;
            sr[7] <= 1'h1;
            if (vpp_low) // supply looked at only now
                sr[4:3] <= 2'h3;
            else if (!rp_vhh && (cmd == 8'hF1 || mlock))
                sr <= sr | 8'h92;
            else if (cmd == 8'hF1)
                mlock <= 1'h1;
        end else if ((ce_n | we_n) && !wq) begin
            if (setup) begin
                setup <= 1'h0;
                arr <= 1'h0;
                if (d_in == 8'h01 || d_in == 8'hF1) begin
                    cmd <= d_in;
                    conf_a <= a;
                    cnt <= busy_cyc;
                    sr[7] <= 1'h0;
                end else
                    sr[5:4] <= 2'h3;
            end else if (d_in == 8'h60)
                setup <= 1'h1;
            else if (d_in == 8'h50)
                sr <= 8'h80; // only command that drops error bits; rp_n low drops them too
            else
                arr <= d_in == 8'hFF;
        end
    end
endmodule // fsl_flash_model

/* verification/fsl_ctrl_tb_top.sv */
// fsl_ctrl_tb_top.sv: self-checking bench of the lock-set controller
// assumes: flash model on the flash pins, this bench as AHB master
module fsl_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // wires and expected state
    logic        clk = 1'h0, rst_b = 1'h0, hwr = 1'h0, vpp_low = 1'h0, rp_vhh = 1'h0;
    logic        ms_e = 1'h0, hrdy, hresp, dq_oe, ce_n, oe_n, we_n, rb_n, rp_n;
    logic [1:0]  htr = 2'h0;
    logic [31:0] hadr = 32'h0, hwd = 32'h0, hrd;
    logic [20:0] fa;
    logic [7:0]  dq_o, dq_m, busy = 8'h20, sr_e = 8'h80;
    logic [4:0]  fs_e = 5'h0;
    int          miscompares = 0, samples_checked = 0;
    wire  [7:0]  dq_w = dq_oe ? dq_o : dq_m;
    always #20 clk = ~clk;
    fsl_ctrl i_dut (
        .CLK(clk), .RST_B(rst_b), .HADDR(hadr), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2),
        .HWDATA(hwd), .HSEL(1'h1), .HREADY(hrdy), .HRDATA(hrd), .HREADYOUT(hrdy), .HRESP(hresp),
        .FLASH_A(fa), .FLASH_DQ_I(dq_w), .FLASH_DQ_O(dq_o), .FLASH_DQ_OE(dq_oe),
        .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .READY_BUSY_N_PIN(rb_n),
        .RESET_POWERDOWN_N_PIN(rp_n));
    fsl_flash_model i_flash (
        .clk(clk), .a(fa), .d_in(dq_w), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n),
        .vpp_low(vpp_low), .rp_vhh(rp_vhh), .busy_cyc(busy), .dq(dq_m), .rb_n(rb_n));
    // ============================================================
    // checking and bus tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hwait;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'h1 && n < 200);
        if (n >= 200) begin
            miscompares++;
            test_done;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
        htr <= 2'h2;
        hadr <= {24'h0, ad};
        hwr <= w;
        hwait;
        htr <= 2'h0;
        hwd <= wd;
        hwait;
        rd = hrd;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, ad, d, x);
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] r);
        bus(1'h0, ad, 32'h0, r);
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] v, output logic [31:0] r);
        int n;
        n = 0;
        do begin
            rd(8'h08, r);
            n++;
        end while ((r & m) !== v && n < 300);
        if (n >= 300) begin
            miscompares++;
            test_done;
        end
    endtask
    // ============================================================
    // expected device status and fault summary
    function automatic logic [7:0] nxt(input logic [7:0] s, input logic m);
        if (vpp_low)
            s[4:3] = 2'h3;
        else if (!rp_vhh && (m || ms_e))
            s = s | 8'h12;
        return s;
    endfunction
    function automatic logic [4:0] cls(input logic [7:0] s);
        return {s[1], s[3], s[5] & s[4], s[4], s[5]};
    endfunction
    // one lock set; supply level flips after the confirm, only its end value counts
    task automatic op(input logic m, input logic f, input logic v, input logic [31:0] a);
        logic [31:0] r;
        wr(8'h04, a);
        wr(8'h00, {29'h0, f, m, 1'h1});
        vpp_low <= #800 v;
        wr(8'h04, ~a);
        poll(32'h600, 32'h400, r);
        sr_e = nxt(sr_e, m);
        ms_e = ms_e | (m & ~vpp_low & rp_vhh);
        if (f)
            fs_e = fs_e | cls(sr_e);
        chk(r & 32'hFFE, {20'h0, 4'hC, sr_e & 8'hFE});
        rd(8'h0C, r);
        chk(r, {27'h0, fs_e});
        rd(8'h04, r);
        chk(r, a & 32'h1FFFFF);
        if (!m)
            chk({11'h0, i_flash.conf_a}, a & 32'h1FFFFF);
    endtask
    // ============================================================
    // main sequence
    initial begin
        logic [31:0] r;
        logic        m;
        void'($urandom(32'h5C2F4372));
        repeat (8) @(posedge clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge clk);
        rd(8'h08, r);
        chk(r & 32'hFF, 32'h80);
        wr(8'h10, 32'hFFFFFFFF);
        rd(8'h10, r);
        chk(r, 32'h0);
        // first five: block ok, master refused, master ok, block refused, low supply
        for (int i = 0; i < 24; i++) begin
            m = i < 5 ? i == 1 || i == 2 : 1'($urandom);
            rp_vhh <= i < 5 ? i == 2 : 1'($urandom);
            vpp_low <= 1'h1;
            busy <= 8'h18 + 8'($urandom % 24);
            op(m, i % 4 != 1, i < 5 ? i == 4 : $urandom % 4 == 0, $urandom);
        end
        wr(8'h00, 32'h8);
        poll(32'h300, 32'h0, r);
        rd(8'h0C, r);
        chk(r, 32'h0);
        sr_e = 8'h80;
        fs_e = 5'h0;
        rp_vhh <= 1'h1;
        op(1'h0, 1'h1, 1'h0, 32'h155);
        wr(8'h00, 32'h10);
        poll(32'h300, 32'h0, r);
        chk({31'h0, i_flash.arr}, 32'h1);
        chk({31'h0, rb_n}, 32'h1);
        test_done;
    end
endmodule // fsl_ctrl_tb_top
